// *** dv/dpsd_ctrl_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ---
// controller side pin driver
// ---
module dpsd_ctrl_model (
   input wire logic mclk,
   input wire logic [21:0] req,
   output logic cke_pin,
   output logic cs_n_pin,
   output logic ras_n_pin,
   output logic cas_n_pin,
   output logic we_n_pin,
   output logic odt_pin,
   output logic [2:0] ba_pin,
   output logic [12:0] addr_pin
);
   // pins defined from time zero, before the first falling edge
   initial begin
      {cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, odt_pin} = 6'h1e;
      ba_pin = 3'h0;
      addr_pin = 13'h0;
   end
   // move pins half a cycle clear of sampling; cke and nop slots as sequenced
   always @(negedge mclk) begin
      {cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, odt_pin, ba_pin} <= req[21:13];
      // address is don't-care on idle slots: toggle so no stale value lingers
      addr_pin <= (req[20] || req[19:17] == 3'h7) ? ~addr_pin : req[12:0];
   end
endmodule // dpsd_ctrl_model
`default_nettype wire

// *** dv/dpsd_power_state_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
// ---
// port checker
// ---
module dpsd_power_state_chk (
   input wire logic mclk,
   input wire logic srst,
   input wire logic cke_pin,
   input wire logic cs_n_pin,
   input wire logic ras_n_pin,
   input wire logic cas_n_pin,
   input wire logic we_n_pin,
   input wire logic [2:0] ba_pin,
   input wire logic [12:0] addr_pin,
   input wire logic [3:0] cas_lat,
   input wire logic [3:0] cas_wr_lat,
   input wire logic [3:0] add_lat,
   input wire logic in_power_down,
   input wire logic in_self_refresh,
   input wire logic internal_refresh_en,
   input wire logic odt_effective,
   input wire logic dll_off,
   input wire logic latency_ok,
   input wire logic [4:0] read_strobe_lat,
   input wire logic cmd_taken,
   input wire logic burst_busy
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   // raw pin decode; the synchroniser delay is allowed for at each use
   logic real_cmd;
   logic mr1_wr;
   assign real_cmd = !cs_n_pin && {ras_n_pin, cas_n_pin, we_n_pin} != 3'h7;
   assign mr1_wr = !cs_n_pin && {ras_n_pin, cas_n_pin, we_n_pin} == 3'h0 && ba_pin == 3'h1;
   // state and output relations
   AST_PD_NO_REFRESH: assert property (in_power_down |-> !internal_refresh_en)
      else $error("refresh running in power-down");
   AST_ODT_OFF: assert property (in_self_refresh |-> !odt_effective)
      else $error("termination live in self-refresh");
   AST_LAT_OK: assert property (latency_ok == !(dll_off && {cas_lat, cas_wr_lat} != 8'h66))
      else $error("latency support flag wrong");
   AST_STROBE: assert property (!$past(srst) |-> read_strobe_lat ==
      $past({1'b0, add_lat} + {1'b0, cas_lat} - {4'h0, dll_off}))
      else $error("read strobe latency wrong");
   AST_SR_ENTRY: assert property ($rose(in_self_refresh) |-> !$past(burst_busy))
      else $error("self-refresh entered during a burst");
   AST_WAKE: assert property (cke_pin [*6] |-> !in_power_down && !in_self_refresh)
      else $error("still asleep with clock enable high");
   AST_CMD_REAL: assert property (cmd_taken |-> $past(real_cmd, 2) || $past(real_cmd, 3))
      else $error("command taken from an idle slot");
   AST_DLL_SRC: assert property (!$past(srst) && $changed(dll_off) |->
      $past(mr1_wr, 3) || $past(mr1_wr, 4))
      else $error("dll control changed without a mode write");
   // main scenarios reached
   COV_SR: cover property (in_self_refresh);
   COV_PD: cover property (in_power_down);
   COV_DLL: cover property ($fell(dll_off));
endmodule // dpsd_power_state_chk
bind dpsd_power_state dpsd_power_state_chk dpsd_power_state_chk_i (.*);
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
// ---
// bench top
// ---
module testbench;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [21:0] req = 22'h1e0000;
   logic [3:0] cas_lat = 4'h6;
   logic [3:0] cas_wr_lat = 4'h6;
   logic [3:0] add_lat = 4'h0;
   logic cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, odt_pin, off;
   logic [2:0] ba_pin, power_state;
   logic [12:0] addr_pin;
   logic in_power_down, in_self_refresh, internal_refresh_en, odt_effective;
   logic dll_off, latency_ok, cmd_taken, burst_busy;
   logic [4:0] read_strobe_lat;
   int n_mismatch = 0;
   int n_tests = 0;
   int cyc = 0;
   int seed = 3;
   dpsd_ctrl_model dpsd_ctrl_model_i (.*);
   dpsd_power_state dpsd_power_state_i (.*);
   initial begin
      forever #10 mclk = ~mclk;
   end
   // a hang costs a mismatch rather than a stuck run
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   // one slot; bit 3 of cmd forces deselect, idle slots pick nop or deselect at random
   task automatic step(input logic cke, input logic [3:0] cmd, input logic [15:0] ba_addr);
      logic des;
      des = cmd[3] || (cmd[2:0] == 3'h7 && $random(seed) % 2 != 0);
      @(posedge mclk);
      #1 req = {cke, des, cmd[2:0], $random(seed) % 2 != 0, ba_addr};
   endtask
   task automatic idle(input logic cke, input int n);
      repeat (n) step(cke, 4'h7, 16'h0);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [4:0] exp_lat(input logic [3:0] al, cl, input logic o);
      return {1'b0, al} + {1'b0, cl} - {4'h0, o};
   endfunction
   function automatic logic exp_ok(input logic [3:0] cl, cwl, input logic o);
      return !o || (cl == 4'h6 && cwl == 4'h6);
   endfunction
   task automatic wrap_up();
      $display("counts: %0d compared, %0d mismatched", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // main sequence: waits cover the two-flop synchroniser plus the state register
   initial begin
      repeat (10) @(negedge mclk);
      srst = 1'b0;
      idle(1'b1, 4);
      idle(1'b0, 6);
      chk(power_state, 8'h3);
      chk({in_power_down, internal_refresh_en}, 8'h2);
      idle(1'b1, 6);
      chk(power_state, 8'h0);
      $display("test precharge power-down done");
      step(1'b1, 4'h3, 16'h4000);
      // the command sits in the second synchroniser stage two slots later
      idle(1'b1, 2);
      chk(cmd_taken, 8'h1);
      idle(1'b1, 2);
      chk(power_state, 8'h1);
      // entry on a nop or deselect: a refresh with a bank open is not legal here
      step(1'b0, 4'h7, 16'h0);
      idle(1'b0, 6);
      chk(power_state, 8'h2);
      idle(1'b1, 6);
      chk(power_state, 8'h1);
      step(1'b1, 4'h5, 16'h4000);
      idle(1'b1, 4);
      chk(burst_busy, 8'h1);
      idle(1'b1, 6);
      chk(burst_busy, 8'h0);
      step(1'b1, 4'h2, 16'h0400);
      idle(1'b1, 4);
      chk(power_state, 8'h0);
      step(1'b1, 4'hb, 16'h4000);
      idle(1'b1, 2);
      chk(cmd_taken, 8'h0);
      idle(1'b1, 2);
      chk(power_state, 8'h0);
      // read with auto precharge, power-down entered while the burst runs
      step(1'b1, 4'h3, 16'ha000);
      idle(1'b1, 4);
      step(1'b1, 4'h5, 16'ha400);
      step(1'b0, 4'h7, 16'h0);
      idle(1'b0, 8);
      chk(power_state, 8'h3);
      idle(1'b1, 6);
      chk(power_state, 8'h0);
      $display("test active power-down and deselect done");
      step(1'b0, 4'h1, 16'h0);
      idle(1'b0, 4);
      repeat (4) begin
         idle(1'b0, 1);
         chk({power_state, internal_refresh_en, odt_effective}, 8'h12);
      end
      idle(1'b1, 12);
      chk({in_self_refresh, power_state}, 8'h0);
      $display("test self-refresh done");
      for (int i = 0; i < 6; i++) begin
         off = i[0];
         step(1'b1, 4'h0, {3'h1, 12'h0, off});
         @(negedge mclk);
         cas_lat = (i == 5) ? 4'h6 : 4'h5 + 4'($unsigned($random(seed)) % 7);
         cas_wr_lat = (i > 3) ? 4'h6 : 4'h5 + 4'($unsigned($random(seed)) % 3);
         add_lat = 4'($unsigned($random(seed)) % 3);
         idle(1'b1, 5);
         chk(dll_off, {7'h0, off});
         chk(read_strobe_lat, exp_lat(add_lat, cas_lat, off));
         chk(latency_ok, exp_ok(cas_lat, cas_wr_lat, off));
      end
      $display("test dll-off latency done");
      @(negedge mclk);
      srst = 1'b1;
      repeat (3) @(negedge mclk);
      srst = 1'b0;
      chk({dll_off, power_state}, 8'h0);
      $display("test second reset done");
      wrap_up();
   end
endmodule // testbench
`default_nettype wire

// *** verilog/dpsd_bank_track.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// bank open tracker
// ----------------------------------------
module dpsd_bank_track #(
   parameter int NUM_BANKS = 8
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic cmd_act,
   input wire logic cmd_pre,
   input wire logic pre_all,
   input wire logic auto_pre,
   input wire logic [2:0] bank,
   output logic any_open
);
   logic [NUM_BANKS-1:0] open_bits;
   logic [NUM_BANKS-1:0] next_open_bits;

   // the bank field is three bits wide, so only eight banks can be addressed
   if (NUM_BANKS != 8) begin : g_bad_banks
      $error("dpsd_bank_track: bank field is 3 bits");
   end

   // open on activate, close on precharge or auto precharge
   always_comb begin
      next_open_bits = open_bits;
      if (cmd_act) begin
         next_open_bits[bank] = 1'b1;
      end else if (cmd_pre && pre_all) begin
         next_open_bits = '0;
      end else if (cmd_pre || auto_pre) begin
         next_open_bits[bank] = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         open_bits <= '0;
      end else begin
         open_bits <= next_open_bits;
      end
   end

   assign any_open = |open_bits;
endmodule // dpsd_bank_track
`default_nettype wire

// *** verilog/dpsd_params.svh ***
`ifndef DPSD_PARAMS_SVH
`define DPSD_PARAMS_SVH
// mode register 1 address and dll-off bit position
`define DPSD_MR_SEL_MR1 3'h1
`define DPSD_MR1_DLL_OFF_BIT 0
// latency pair supported while the dll is off
`define DPSD_DLL_OFF_CL 4'h6
`define DPSD_DLL_OFF_CWL 4'h6
// command codes {ras_n, cas_n, we_n}
`define DPSD_CMD_MRS 3'h0
`define DPSD_CMD_REF 3'h1
`define DPSD_CMD_PRE 3'h2
`define DPSD_CMD_ACT 3'h3
`define DPSD_CMD_WR 3'h4
`define DPSD_CMD_RD 3'h5
`define DPSD_CMD_NOP 3'h7
// burst length in clock cycles (bl8)
`define DPSD_BURST_CYC 4'h4
`endif

// *** verilog/dpsd_pkg.sv ***
`default_nettype none
package dpsd_pkg;
   typedef enum logic [2:0] {
      DPSD_IDLE,
      DPSD_ACTIVE,
      DPSD_ACT_PD,
      DPSD_PRE_PD,
      DPSD_SELF_REF
   } dpsd_state_e;
endpackage
`default_nettype wire

// *** verilog/dpsd_power_state.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "dpsd_params.svh"
// Functional notes
// [R1] sample cke each edge, decide from pair
// [R2] action follows command at same edge; odt ignored
// [R3] controller holds cke for minimum pulse count
// [R4] only nop/deselect during self-refresh exit period
// [R5] self-refresh entry only from all-idle with refresh
// [R6] no self-refresh entry during bursts
// [R7] power-down entry/exit edge carries nop/deselect
// [R8] self-refresh exit edge carries nop/deselect
// [R9] no internal refresh during power-down
// [R10] classify power-down after burst by banks
// [R11] odt ignored during self-refresh
// [R12] first write 512 cycles after self-refresh exit
// [R13] controller avoids reserved cke combinations
// [R14] nop registers nothing, leaves operations running
// [R15] deselect accepts nothing, operations continue
// [R16] mr1 bit a0 one disables the dll
// [R17] dll bit may change any time
// [R18] dll-off clock below its maximum frequency
// [R19] dll-off supports cl six, cwl six
// [R20] dll-off read strobe referenced al+cl-1
// [R21] only clock-to-strobe shifts, strobe-to-data unchanged
// [R22] controller tolerates wide dll-off strobe delay
// [R23] self-refresh exit without depending on clock; here exit waits for cke to pass the mclk synchroniser
// [R24] track open banks to classify power-down
module dpsd_power_state (
   input wire logic mclk,
   input wire logic srst,
   input wire logic cke_pin,
   input wire logic cs_n_pin,
   input wire logic ras_n_pin,
   input wire logic cas_n_pin,
   input wire logic we_n_pin,
   input wire logic odt_pin,
   input wire logic [2:0] ba_pin,
   input wire logic [12:0] addr_pin,
   input wire logic [3:0] cas_lat,
   input wire logic [3:0] cas_wr_lat,
   input wire logic [3:0] add_lat,
   output logic [2:0] power_state,
   output logic in_power_down,
   output logic in_self_refresh,
   output logic internal_refresh_en,
   output logic odt_effective,
   output logic dll_off,
   output logic latency_ok,
   output logic [4:0] read_strobe_lat,
   output logic cmd_taken,
   output logic burst_busy
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // the first stage is read only by the second stage
   logic [21:0] pin_s1;
   logic [21:0] pin_s2;
   always_ff @(posedge mclk) begin
      pin_s1 <= {cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, odt_pin, ba_pin, addr_pin};
      pin_s2 <= pin_s1;
   end

   logic cke;
   logic cs_n;
   logic [2:0] cmd;
   logic odt;
   logic [2:0] ba;
   logic [12:0] addr;
   assign cke = pin_s2[21];
   assign cs_n = pin_s2[20];
   assign cmd = pin_s2[19:17];
   assign odt = pin_s2[16];
   assign ba = pin_s2[15:13];
   assign addr = pin_s2[12:0];

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   function automatic logic is_cmd(input logic sel_n, input logic [2:0] c,
                                   input logic [2:0] code);
      is_cmd = !sel_n && (c == code);
   endfunction

   logic cke_prev;
   logic cmd_ok;
   logic do_act;
   logic do_pre;
   logic do_rd;
   logic do_wr;
   logic do_mrs;
   logic nop_or_des;
   // commands only count on an edge with cke high before and now
   assign cmd_ok = cke_prev && cke;
   // a nop or deselect registers nothing, bursts keep running
   assign nop_or_des = cs_n || is_cmd(cs_n, cmd, `DPSD_CMD_NOP); // [R14] [R15]
   assign do_act = cmd_ok && is_cmd(cs_n, cmd, `DPSD_CMD_ACT); // [R2]
   assign do_pre = cmd_ok && is_cmd(cs_n, cmd, `DPSD_CMD_PRE);
   assign do_rd = cmd_ok && is_cmd(cs_n, cmd, `DPSD_CMD_RD);
   assign do_wr = cmd_ok && is_cmd(cs_n, cmd, `DPSD_CMD_WR);
   assign do_mrs = cmd_ok && is_cmd(cs_n, cmd, `DPSD_CMD_MRS);
   assign cmd_taken = cmd_ok && !nop_or_des; // [R15]

   // ----------------------------------------
   // burst tracking and bank tracking
   // ----------------------------------------
   logic [3:0] burst_cnt;
   logic [3:0] next_burst_cnt;
   logic pend_ap;
   logic next_pend_ap;
   logic [2:0] pend_bank;
   logic [2:0] next_pend_bank;
   logic any_open;
   logic ap_close;

   // bursts run to completion; nop and deselect never cut them short
   always_comb begin
      next_burst_cnt = burst_cnt;
      next_pend_ap = pend_ap;
      next_pend_bank = pend_bank;
      if (do_rd || do_wr) begin
         next_burst_cnt = `DPSD_BURST_CYC;
         next_pend_ap = addr[10];
         next_pend_bank = ba;
      end else if (burst_cnt != 4'h0) begin
         next_burst_cnt = burst_cnt - 4'h1; // [R14]
         if (burst_cnt == 4'h1) begin
            next_pend_ap = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         burst_cnt <= 4'h0;
         pend_ap <= 1'b0;
         pend_bank <= 3'h0;
      end else begin
         burst_cnt <= next_burst_cnt;
         pend_ap <= next_pend_ap;
         pend_bank <= next_pend_bank;
      end
   end

   assign burst_busy = burst_cnt != 4'h0;
   // auto precharge closes the bank as the burst concludes
   assign ap_close = pend_ap && (burst_cnt == 4'h1);

   dpsd_bank_track #(
      .NUM_BANKS(8)
   ) u_banks (
      .mclk(mclk),
      .srst(srst),
      .cmd_act(do_act),
      .cmd_pre(do_pre),
      .pre_all(addr[10]),
      .auto_pre(ap_close),
      .bank(ap_close ? pend_bank : ba),
      .any_open(any_open) // [R24]
   );

   // ----------------------------------------
   // power state machine
   // ----------------------------------------
   dpsd_pkg::dpsd_state_e state;
   dpsd_pkg::dpsd_state_e next_state;
   logic pd_pending;
   logic next_pd_pending;

   // decided from the cke pair and the current state
   always_comb begin
      next_state = state;
      next_pd_pending = pd_pending;
      case (state)
         dpsd_pkg::DPSD_IDLE, dpsd_pkg::DPSD_ACTIVE: begin
            if (cke_prev && !cke) begin // [R1]
               if (is_cmd(cs_n, cmd, `DPSD_CMD_REF) && !any_open && !burst_busy) begin
                  next_state = dpsd_pkg::DPSD_SELF_REF; // [R5] [R6]
               end else if (burst_busy) begin
                  // classify once the burst has finished
                  next_state = dpsd_pkg::DPSD_ACT_PD;
                  next_pd_pending = 1'b1; // [R10]
               end else if (any_open) begin
                  next_state = dpsd_pkg::DPSD_ACT_PD;
               end else begin
                  next_state = dpsd_pkg::DPSD_PRE_PD;
               end
            end else if (cke) begin
               next_state = any_open ? dpsd_pkg::DPSD_ACTIVE : dpsd_pkg::DPSD_IDLE;
            end
         end
         dpsd_pkg::DPSD_ACT_PD, dpsd_pkg::DPSD_PRE_PD: begin
            if (pd_pending && !burst_busy) begin
               next_pd_pending = 1'b0;
               next_state = any_open ? dpsd_pkg::DPSD_ACT_PD : dpsd_pkg::DPSD_PRE_PD; // [R10]
            end
            if (!cke_prev && cke) begin // [R1]
               next_pd_pending = 1'b0;
               next_state = any_open ? dpsd_pkg::DPSD_ACTIVE : dpsd_pkg::DPSD_IDLE;
            end
         end
         dpsd_pkg::DPSD_SELF_REF: begin
            // exit is taken on the synchronised cke edge; a stopped clock only delays it
            if (!cke_prev && cke) begin // [R1] [R23]
               next_state = dpsd_pkg::DPSD_IDLE;
            end
         end
         default: begin
            next_state = dpsd_pkg::DPSD_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         state <= dpsd_pkg::DPSD_IDLE;
         pd_pending <= 1'b0;
         cke_prev <= 1'b0;
      end else begin
         state <= next_state;
         pd_pending <= next_pd_pending;
         cke_prev <= cke;
      end
   end

   assign power_state = state;
   assign in_power_down = (state == dpsd_pkg::DPSD_ACT_PD) || (state == dpsd_pkg::DPSD_PRE_PD);
   assign in_self_refresh = state == dpsd_pkg::DPSD_SELF_REF;
   // power-down never refreshes; self-refresh does its own
   assign internal_refresh_en = in_self_refresh; // [R9]
   // termination is unavailable in self-refresh; only the synchronised odt is read
   assign odt_effective = odt && !in_self_refresh; // [R11]

   // ----------------------------------------
   // dll control and read strobe latency
   // ----------------------------------------
   logic next_dll_off;
   // mr1 may be written during init or at any later time
   always_comb begin
      next_dll_off = dll_off;
      if (do_mrs && (ba == `DPSD_MR_SEL_MR1)) begin // [R17]
         next_dll_off = addr[`DPSD_MR1_DLL_OFF_BIT]; // [R16]
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         dll_off <= 1'b0;
      end else begin
         dll_off <= next_dll_off;
      end
   end

   // with the dll off only one latency pair is guaranteed
   assign latency_ok = !dll_off || ((cas_lat == `DPSD_DLL_OFF_CL) &&
                                    (cas_wr_lat == `DPSD_DLL_OFF_CWL)); // [R19]

   // strobe window moves one cycle earlier; dq-to-dqs skew is untouched
   always_ff @(posedge mclk) begin
      if (srst) begin
         read_strobe_lat <= 5'h0;
      end else begin
         read_strobe_lat <= {1'b0, add_lat} + {1'b0, cas_lat} - {4'h0, dll_off}; // [R20] [R21]
      end
   end
endmodule // dpsd_power_state
`default_nettype wire
